// ===== rtl/lcoc_pkg.sv
package lcoc_pkg;
  localparam int CLK_HZ = 200_000_000;
  // reset closure window, in milliseconds
  localparam int RST_MIN_MS = 250;
  localparam int RST_MAX_MS = 2000;
  localparam longint RST_MIN_CYC_L = (longint'(RST_MIN_MS) * CLK_HZ + 999) / 1000;
  localparam longint RST_MAX_CYC_L = (longint'(RST_MAX_MS) * CLK_HZ) / 1000;
  localparam int RST_MIN_CYC = int'(RST_MIN_CYC_L);
  localparam int RST_MAX_CYC = int'(RST_MAX_CYC_L);
  // indicator flash half period
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = int'((longint'(FLASH_MS) * CLK_HZ) / 1000);
  localparam int NUM_BEAMS = 20;
  localparam int NUM_ZONES = 4;
  // feedback check modes
  localparam logic [1:0] FB_NONE = 2'h0;
  localparam logic [1:0] FB_ONE = 2'h1;
  localparam logic [1:0] FB_TWO = 2'h2;
  // display code kinds
  localparam logic [1:0] DSP_COUNT = 2'h0;
  localparam logic [1:0] DSP_ERROR = 2'h1;
  localparam logic [1:0] DSP_CONFIG = 2'h2;
  // error numbers
  localparam logic [7:0] ERR_SELF = 8'h01;
  localparam logic [7:0] ERR_FEEDBACK = 8'h02;
  localparam logic [7:0] ERR_NONE = 8'h00;
  // emitter indicator codes
  localparam logic [1:0] EMI_RUN = 2'h0;
  localparam logic [1:0] EMI_TEST = 2'h1;
  localparam logic [1:0] EMI_LOCK = 2'h2;
  typedef enum logic [2:0] {
    LCOC_POWERUP,
    LCOC_WAIT_RESET,
    LCOC_RUN,
    LCOC_STOP,
    LCOC_LOCKOUT
  } lcoc_state_e;
endpackage

// ===== rtl/lcoc_output_control.sv
`timescale 1ns/1ps
// Overview of operation
// - trip mode: outputs on after self-test, sync pass and all beams clear
// - trip mode: outputs restore automatically once all beams clear again
// - latch mode: outputs stay off after power-up until valid manual reset
// - self-check failure after power-up stops the machine and enters lockout
// - any lockout holds both safety outputs off
// - manual reset leaves power-up lockout, latched stop, corrected internal lockout
// - valid reset: input closed 1/4 s to 2 s, then opened
// - only open-closed-open acts; held or shorted input never resets
// - feedback check modes: none, one channel, two channels
// - one-channel mode: auxiliary output follows safety outputs
// - open test contact stops emission, seen as blocked beams
// - beams accepted only when emitter and receiver scan codes match
// - reduced resolution tolerates up to two consecutive blocked beams, not sync
// - status indicator flashes green in run while reduced resolution is on
// - zone indicator: green clear, red blocked, flashing green blanked
// - reset indicator steady in run, flashing while waiting reset
// - status green when outputs on, red off, flashing red lockout
// - lockout shows error number on display
// - display shows config, error code or count of blocked beams
// - power cycle over 2 s clears corrected lockout
// - trip mode works with reset input left open
// - emitter indicator shows run, test, lockout; digit shows codes
module lcoc_output_control
  import lcoc_pkg::*;
#(
  parameter int BEAMS = NUM_BEAMS,
  parameter int ZONES = NUM_ZONES,
  parameter int RST_MIN = RST_MIN_CYC,
  parameter int RST_MAX = RST_MAX_CYC,
  parameter int FLASH = FLASH_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic latchMode,
  input wire logic selfTestOk,
  input wire logic syncOk,
  input wire logic componentFault,
  input wire logic [BEAMS-1:0] beamClear,
  input wire logic testContactClosed,
  input wire logic emitScanCode,
  input wire logic rxScanCode,
  input wire logic reducedRes,
  input wire logic [ZONES-1:0] zoneBlanked,
  input wire logic [1:0] externalFeedbackCheckMode,
  input wire logic [1:0] primaryStopElementFb,
  input wire logic resetClosed,
  output logic safetyOutputPairA,
  output logic safetyOutputPairB,
  output logic auxOut,
  output logic emitterOn,
  output logic statusGreen,
  output logic statusRed,
  output logic resetLed,
  output logic [ZONES-1:0] zoneGreen,
  output logic [ZONES-1:0] zoneRed,
  output logic [1:0] dispKind,
  output logic [7:0] dispValue,
  output logic [1:0] emitIndicator,
  output logic [3:0] emitDigit
);
  localparam int BW = $clog2(BEAMS + 1);
  localparam int ZB = BEAMS / ZONES;
  localparam int CW = $clog2(RST_MAX + 2);
  localparam int FW = $clog2(FLASH + 1);

  if (BEAMS < 3 || ZONES < 1 || BEAMS % ZONES != 0 || RST_MIN < 1 || RST_MAX <= RST_MIN
      || FLASH < 1 || BEAMS > 255) begin : g_bad_params
    $error("lcoc_output_control: unsupported parameters");
  end

  function automatic logic [BW-1:0] countBlocked(input logic [BEAMS-1:0] clr);
    logic [BW-1:0] n;
    n = '0;
    for (int i = 0; i < BEAMS; i++) begin
      n = n + BW'(!clr[i]);
    end
    return n;
  endfunction

  // beam zero is the sync beam; run of three blocked beams trips
  function automatic logic beamsTrip(input logic [BEAMS-1:0] clr, input logic tol);
    logic t;
    t = !clr[0];
    for (int i = 1; i < BEAMS; i++) begin
      if (!tol && !clr[i]) begin
        t = 1'b1;
      end
      if (tol && i >= 3 && !clr[i] && !clr[i-1] && !clr[i-2]) begin
        t = 1'b1;
      end
    end
    return t;
  endfunction

  lcoc_state_e state_ff;
  lcoc_state_e shadow_ff;
  logic [BEAMS-1:0] seenClear;
  logic beamsOk;
  logic resetPulse_ff;
  logic [CW-1:0] closeCnt_ff;
  logic closing_ff;
  logic fbFault;
  logic fbOkLock_ff;
  logic [7:0] errCode_ff;
  logic [FW-1:0] flashCnt_ff;
  logic flash_ff;
  logic outOn;

  // emitter dark or scan mismatch reads as every beam blocked
  assign seenClear = (testContactClosed && emitScanCode == rxScanCode) ? beamClear : '0;
  assign beamsOk = !beamsTrip(seenClear, reducedRes);

  // feedback: contacts must be open (fb low) while outputs are on, closed while off
  always_comb begin
    fbFault = 1'b0;
    unique case (externalFeedbackCheckMode)
      FB_ONE: fbFault = fbOkLock_ff && (primaryStopElementFb[0] == outOn);
      FB_TWO: fbFault = fbOkLock_ff && ((primaryStopElementFb[0] == outOn)
                                     || (primaryStopElementFb[1] == outOn));
      default: fbFault = 1'b0;
    endcase
  end

  // feedback checked only after outputs have settled one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fbOkLock_ff <= 1'b0;
    end else begin
      fbOkLock_ff <= (state_ff == LCOC_RUN) == outOn;
    end
  end

  // closure timer: open-closed-open within window
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      closeCnt_ff <= '0;
      closing_ff <= 1'b0;
      resetPulse_ff <= 1'b0;
    end else begin
      resetPulse_ff <= 1'b0;
      if (resetClosed) begin
        closing_ff <= 1'b1;
        if (closeCnt_ff <= CW'(RST_MAX)) begin
          closeCnt_ff <= closeCnt_ff + CW'(1);
        end
      end else begin
        if (closing_ff && closeCnt_ff >= CW'(RST_MIN) && closeCnt_ff <= CW'(RST_MAX)) begin
          resetPulse_ff <= 1'b1;
        end
        closing_ff <= 1'b0;
        closeCnt_ff <= '0;
      end
    end
  end

  // sys_rst stands for power return, so a long power cycle restarts here
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= LCOC_POWERUP;
      errCode_ff <= ERR_NONE;
    end else if (componentFault || !selfTestOk) begin
      if (state_ff != LCOC_POWERUP) begin
        state_ff <= LCOC_LOCKOUT;
        errCode_ff <= ERR_SELF;
      end
    end else if (fbFault) begin
      state_ff <= LCOC_LOCKOUT;
      errCode_ff <= ERR_FEEDBACK;
    end else begin
      unique case (state_ff)
        LCOC_POWERUP: begin
          if (syncOk && beamsOk) begin
            state_ff <= latchMode ? LCOC_WAIT_RESET : LCOC_RUN;
          end
        end
        LCOC_WAIT_RESET: begin
          if (resetPulse_ff && beamsOk && syncOk) begin
            state_ff <= LCOC_RUN;
          end
        end
        LCOC_RUN: begin
          if (!beamsOk || !syncOk) begin
            state_ff <= LCOC_STOP;
          end
        end
        LCOC_STOP: begin
          if (!latchMode && beamsOk && syncOk) begin
            state_ff <= LCOC_RUN;
          end else if (latchMode && beamsOk && syncOk) begin
            state_ff <= LCOC_WAIT_RESET;
          end
        end
        LCOC_LOCKOUT: begin
          if (resetPulse_ff) begin
            state_ff <= LCOC_POWERUP;
            errCode_ff <= ERR_NONE;
          end
        end
      endcase
    end
  end

  // redundant copy of the run decision
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shadow_ff <= LCOC_POWERUP;
    end else begin
      shadow_ff <= state_ff;
    end
  end

  assign outOn = safetyOutputPairA && safetyOutputPairB;

  // both channels from the run condition, B also gated by shadow_ff, off in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      safetyOutputPairA <= 1'b0;
      safetyOutputPairB <= 1'b0;
      auxOut <= 1'b0;
    end else begin
      safetyOutputPairA <= state_ff == LCOC_RUN && beamsOk && !componentFault;
      safetyOutputPairB <= state_ff == LCOC_RUN && shadow_ff != LCOC_LOCKOUT && beamsOk
                           && !componentFault;
      auxOut <= (externalFeedbackCheckMode == FB_ONE)
                && state_ff == LCOC_RUN && beamsOk && !componentFault;
    end
  end

  // flash timebase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flashCnt_ff <= '0;
      flash_ff <= 1'b0;
    end else if (flashCnt_ff == FW'(FLASH - 1)) begin
      flashCnt_ff <= '0;
      flash_ff <= !flash_ff;
    end else begin
      flashCnt_ff <= flashCnt_ff + FW'(1);
    end
  end

  // indicators and displays
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      emitterOn <= 1'b0;
      statusGreen <= 1'b0;
      statusRed <= 1'b0;
      resetLed <= 1'b0;
      zoneGreen <= '0;
      zoneRed <= '0;
      dispKind <= DSP_CONFIG;
      dispValue <= 8'h00;
      emitIndicator <= EMI_RUN;
      emitDigit <= 4'h0;
    end else begin
      emitterOn <= testContactClosed;
      if (state_ff == LCOC_LOCKOUT) begin
        statusGreen <= 1'b0;
        statusRed <= flash_ff;
      end else if (state_ff == LCOC_RUN && reducedRes) begin
        statusGreen <= flash_ff;
        statusRed <= 1'b0;
      end else begin
        statusGreen <= state_ff == LCOC_RUN;
        statusRed <= state_ff != LCOC_RUN;
      end
      resetLed <= (state_ff == LCOC_RUN) || (state_ff == LCOC_WAIT_RESET && flash_ff);
      for (int z = 0; z < ZONES; z++) begin
        if (zoneBlanked[z]) begin
          zoneGreen[z] <= flash_ff;
          zoneRed[z] <= 1'b0;
        end else begin
          zoneGreen[z] <= &seenClear[z*ZB +: ZB];
          zoneRed[z] <= !(&seenClear[z*ZB +: ZB]);
        end
      end
      if (state_ff == LCOC_LOCKOUT) begin
        dispKind <= DSP_ERROR;
        dispValue <= errCode_ff;
      end else if (state_ff == LCOC_POWERUP) begin
        dispKind <= DSP_CONFIG;
        dispValue <= {4'h0, reducedRes, latchMode, externalFeedbackCheckMode};
      end else begin
        dispKind <= DSP_COUNT;
        dispValue <= 8'(countBlocked(seenClear));
      end
      if (state_ff == LCOC_LOCKOUT) begin
        emitIndicator <= EMI_LOCK;
        emitDigit <= errCode_ff[3:0];
      end else if (!testContactClosed) begin
        emitIndicator <= EMI_TEST;
        emitDigit <= {3'h0, emitScanCode};
      end else begin
        emitIndicator <= EMI_RUN;
        emitDigit <= {3'h0, emitScanCode};
      end
    end
  end

  // opening edge of a closure that ended below the minimum count
  sequence s_closed_short;
    closing_ff && !resetClosed && closeCnt_ff < CW'(RST_MIN);
  endsequence

  a_lockout_outs_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff == LCOC_LOCKOUT |=> !safetyOutputPairA && !safetyOutputPairB)
    else $error("outputs on during lockout");
  a_fault_to_lock: assert property (@(posedge ref_clk) disable iff (sys_rst)
    componentFault && state_ff != LCOC_POWERUP |=> state_ff == LCOC_LOCKOUT)
    else $error("fault did not lock out");
  a_pair_agree: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(safetyOutputPairA) |-> $fell(safetyOutputPairB) || !$past(safetyOutputPairB))
    else $error("output channels split");
  a_short_close_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_closed_short |=> !resetPulse_ff)
    else $error("short closure produced reset");
  a_held_no_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    resetClosed |=> !resetPulse_ff)
    else $error("reset while input closed");
  a_latch_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff == LCOC_WAIT_RESET && !resetPulse_ff |=> state_ff != LCOC_RUN)
    else $error("latch left without reset");
  a_trip_restore: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff == LCOC_STOP && !latchMode && beamsOk && syncOk && selfTestOk
    && !componentFault && !fbFault |=> state_ff == LCOC_RUN)
    else $error("trip did not restore");
  a_aux_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    externalFeedbackCheckMode == FB_ONE && $stable(externalFeedbackCheckMode)
    |-> auxOut == safetyOutputPairA)
    else $error("aux does not follow outputs");
endmodule

// ===== tb/lcoc_machine_model.sv
`timescale 1ns/1ps
module lcoc_machine_model (
  input wire logic ref_clk,
  input wire logic safetyOutputPairA,
  input wire logic safetyOutputPairB,
  input wire logic welded,
  output logic [1:0] primaryStopElementFb,
  output logic resetClosed
);
  initial begin
    primaryStopElementFb = 2'h3;
    resetClosed = 1'b0;
  end
  // stop element contacts open while energised; a welded pair follows
  always @(negedge ref_clk) begin
    if (welded) begin
      primaryStopElementFb <= {safetyOutputPairB, safetyOutputPairA};
    end else begin
      primaryStopElementFb <= ~{safetyOutputPairB, safetyOutputPairA};
    end
  end
  // switch closed for n cycles, then opened again
  task automatic press(input int n);
    @(negedge ref_clk);
    resetClosed <= 1'b1;
    repeat (n) @(negedge ref_clk);
    resetClosed <= 1'b0;
    @(negedge ref_clk);
  endtask
endmodule

// ===== tb/light_curtain_output_control_tb.sv
`timescale 1ns/1ps
module light_curtain_output_control_tb;
  import lcoc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic latchMode = 1'b0;
  logic selfTestOk = 1'b1;
  logic syncOk = 1'b1;
  logic componentFault = 1'b0;
  logic [19:0] beamClear = 20'hFFFFF;
  logic testContactClosed = 1'b1;
  logic emitScanCode = 1'b0;
  logic rxScanCode = 1'b0;
  logic reducedRes = 1'b0;
  logic [3:0] zoneBlanked = 4'h0;
  logic [1:0] externalFeedbackCheckMode = FB_ONE;
  logic [1:0] primaryStopElementFb;
  logic resetClosed, welded = 1'b0;
  logic safetyOutputPairA, safetyOutputPairB, auxOut, emitterOn, statusGreen, statusRed, resetLed;
  logic [3:0] zoneGreen, zoneRed, emitDigit;
  logic [1:0] emitIndicator;
  logic [1:0] dispKind;
  logic [7:0] dispValue;
  int err_count = 0;
  int samples_checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  lcoc_output_control #(.BEAMS(20), .ZONES(4), .RST_MIN(4), .RST_MAX(20), .FLASH(2)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .latchMode(latchMode), .selfTestOk(selfTestOk),
    .syncOk(syncOk), .componentFault(componentFault), .beamClear(beamClear),
    .testContactClosed(testContactClosed), .emitScanCode(emitScanCode),
    .rxScanCode(rxScanCode), .reducedRes(reducedRes), .zoneBlanked(zoneBlanked),
    .externalFeedbackCheckMode(externalFeedbackCheckMode),
    .primaryStopElementFb(primaryStopElementFb), .resetClosed(resetClosed),
    .safetyOutputPairA(safetyOutputPairA), .safetyOutputPairB(safetyOutputPairB),
    .auxOut(auxOut), .emitterOn(emitterOn), .statusGreen(statusGreen),
    .statusRed(statusRed), .resetLed(resetLed), .zoneGreen(zoneGreen), .zoneRed(zoneRed),
    .dispKind(dispKind), .dispValue(dispValue), .emitIndicator(emitIndicator),
    .emitDigit(emitDigit));
  lcoc_machine_model m (
    .ref_clk(ref_clk), .safetyOutputPairA(safetyOutputPairA),
    .safetyOutputPairB(safetyOutputPairB), .welded(welded),
    .primaryStopElementFb(primaryStopElementFb), .resetClosed(resetClosed));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // bounded wait for both channels at level v
  task automatic outs(input logic v, input int n);
    int i;
    for (i = 0; i < n && {safetyOutputPairA, safetyOutputPairB} !== {v, v}; i++) begin
      @(negedge ref_clk);
    end
    chk({6'h0, safetyOutputPairA, safetyOutputPairB}, {6'h0, v, v});
  endtask
  // flashing output: both levels seen within six cycles
  task automatic blink(input int sel);
    logic [1:0] seen;
    logic b;
    seen = 2'b00;
    repeat (6) begin
      @(negedge ref_clk);
      case (sel)
        0: b = statusGreen;
        1: b = statusRed;
        2: b = resetLed;
        default: b = zoneGreen[2];
      endcase
      seen[b] = 1'b1;
    end
    chk({6'h0, seen}, 8'h03);
  endtask
  task automatic pwr(input logic l);
    latchMode = l;
    sys_rst = 1'b1;
    cyc(5);
    sys_rst = 1'b0;
  endtask
  task automatic t_trip();
    pwr(1'b0);
    outs(1'b1, 4);
    cyc(1);
    chk({7'h0, auxOut}, 8'h01);
    chk({7'h0, statusGreen}, 8'h01);
    beamClear[5] = 1'b0;
    outs(1'b0, 3);
    cyc(1);
    chk({7'h0, auxOut}, 8'h00);
    chk({7'h0, statusRed}, 8'h01);
    beamClear[5] = 1'b1;
    outs(1'b1, 4);
    chk({7'h0, resetLed}, 8'h01);
    syncOk = 1'b0;
    outs(1'b0, 4);
    syncOk = 1'b1;
    outs(1'b1, 4);
    $display("t_trip done");
  endtask
  task automatic t_reduced();
    reducedRes = 1'b1;
    beamClear = 20'hFFF9F;
    zoneBlanked = 4'h4;
    cyc(6);
    outs(1'b1, 0);
    chk({6'h0, dispKind}, {6'h0, DSP_COUNT});
    chk(dispValue, 8'h02);
    chk({4'h0, zoneRed}, 8'h02);
    chk({4'h0, zoneGreen & 4'hB}, 8'h09);
    blink(0);
    blink(3);
    zoneBlanked = 4'h0;
    beamClear = 20'hFFF1F;
    outs(1'b0, 3);
    beamClear = 20'hFFFFF;
    outs(1'b1, 4);
    beamClear = 20'hFFFFE;
    outs(1'b0, 3);
    beamClear = 20'hFFFFF;
    reducedRes = 1'b0;
    outs(1'b1, 4);
    $display("t_reduced done");
  endtask
  task automatic t_emit();
    testContactClosed = 1'b0;
    outs(1'b0, 4);
    chk({7'h0, emitterOn}, 8'h00);
    chk({6'h0, emitIndicator}, {6'h0, EMI_TEST});
    testContactClosed = 1'b1;
    outs(1'b1, 6);
    emitScanCode = 1'b1;
    outs(1'b0, 4);
    rxScanCode = 1'b1;
    outs(1'b1, 6);
    chk({4'h0, emitDigit}, 8'h01);
    chk({6'h0, emitIndicator}, {6'h0, EMI_RUN});
    $display("t_emit done");
  endtask
  task automatic t_latch();
    syncOk = 1'b0;
    pwr(1'b1);
    cyc(2);
    chk({6'h0, dispKind}, {6'h0, DSP_CONFIG});
    chk(dispValue, 8'h05);
    syncOk = 1'b1;
    cyc(10);
    outs(1'b0, 0);
    blink(2);
    m.press(3);
    cyc(6);
    outs(1'b0, 0);
    m.press(21);
    cyc(6);
    outs(1'b0, 0);
    m.press(4);
    outs(1'b1, 6);
    beamClear[9] = 1'b0;
    outs(1'b0, 3);
    beamClear[9] = 1'b1;
    cyc(8);
    outs(1'b0, 0);
    m.press(20);
    outs(1'b1, 6);
    $display("t_latch done");
  endtask
  task automatic t_fault();
    externalFeedbackCheckMode = FB_NONE;
    pwr(1'b0);
    outs(1'b1, 4);
    componentFault = 1'b1;
    outs(1'b0, 2);
    cyc(2);
    chk({6'h0, dispKind}, {6'h0, DSP_ERROR});
    chk(dispValue, ERR_SELF);
    chk({6'h0, emitIndicator}, {6'h0, EMI_LOCK});
    chk({4'h0, emitDigit}, ERR_SELF);
    blink(1);
    componentFault = 1'b0;
    cyc(8);
    outs(1'b0, 0);
    m.press(8);
    outs(1'b1, 8);
    componentFault = 1'b1;
    cyc(3);
    componentFault = 1'b0;
    pwr(1'b0);
    outs(1'b1, 4);
    selfTestOk = 1'b0;
    outs(1'b0, 3);
    selfTestOk = 1'b1;
    m.press(5);
    outs(1'b1, 8);
    $display("t_fault done");
  endtask
  task automatic t_feedback();
    externalFeedbackCheckMode = FB_TWO;
    pwr(1'b0);
    outs(1'b1, 4);
    cyc(4);
    outs(1'b1, 0);
    welded = 1'b1;
    outs(1'b0, 4);
    cyc(2);
    chk(dispValue, ERR_FEEDBACK);
    externalFeedbackCheckMode = FB_NONE;
    pwr(1'b0);
    outs(1'b1, 4);
    cyc(6);
    outs(1'b1, 0);
    welded = 1'b0;
    $display("t_feedback done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done();
  end
  initial begin
    t_trip();
    t_reduced();
    t_emit();
    t_latch();
    t_fault();
    t_feedback();
    test_done();
  end
endmodule
